// *** rtl/lks_top.sv ***
// lcd segment sequencer with shared segment key scan, axi4-lite registers
//
// Overview of operation
// [R01] each segment takes its pattern from its own memory byte, bit n for common n
// [R02] eight-slot mode uses all eight bits, bit 0 to bit 7
// [R03] segments 0 to 23 read consecutive memory bytes FA40H to FA57H
// [R04] a selected segment sits opposite its common, polarity flipping every frame
// [R05] shared pins carry both segment drive and key scan levels
// [R06] key scan enable 0 gives plain frames, 1 inserts key scan periods
// [R07] return input is accepted only from two lcd clocks after flag rise
// [R08] enabled return pulled low in scan period sets flag; software clears it; code never sets it, the hold-off covers both lcd clocks of the scan period
// [R09] software starts key identification only after reading scan flag as 1
// [R10] software drives one scan pin low and watches which return reads low
// [R11] in scan periods shared pins output bits of the two pattern registers
// [R12] bits 0 to 3 drive first half, bits 4 to 7 latter half
// [R13] each half of the scan period lasts exactly one lcd clock
// [R14] no common is selected during scan periods
// [R15] software should program opposite levels in the two halves
// [R16] no scan periods in static mode
// [R17] return input ignored during last lcd clock of the scan period
// [R18] software sets return mode bit to 1 only for used return pins
// [R19] scan flag high through scan periods, low in display periods
`timescale 1ns/1ns
`default_nettype none
`include "lks_consts.svh"
module lks_top import lks_pkg::*; #(
  parameter int LCD_DIV = `LKS_LCD_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // axi4-lite write
  input wire logic [19:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [19:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // lcd panel, segments 16..23 are shared scan output pins 0..7
  output logic [23:0] segmentOutput,
  output logic [7:0] commonSelect,
  output logic commonLevel,
  // key matrix and status
  input wire logic [7:0] returnInput,
  output logic scanPeriodFlag,
  output logic irq
);
  // ************************************************************
  // registers and state
  // ************************************************************
  logic [7:0] dispMem [0:23];
  logic [7:0] ctrl, intStat, intMask, returnMode, patA, patB;
  logic [7:0] retSync;
  logic [31:0] divCnt;
  logic lcdTick;
  lks_state_t state;
  logic [2:0] slot;
  logic [3:0] ksCnt;
  logic [2:0] slotLast;
  logic modeStatic, retHit, ksAccept, frameEnd;

  lks_sync u_lks_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pinIn(returnInput),
    .pinSync(retSync)
  );

  // ************************************************************
  // lcd clock prescaler
  // ************************************************************
  logic [31:0] next_divCnt;
  logic next_lcdTick;

  // one-cycle tick per lcd clock period
  always_comb begin
    next_lcdTick = 1'b0;
    next_divCnt = divCnt + 32'h1;
    if (divCnt >= 32'(LCD_DIV - 1)) begin
      next_divCnt = 32'h0;
      next_lcdTick = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt <= 32'h0;
      lcdTick <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      lcdTick <= next_lcdTick;
    end
  end

  // ************************************************************
  // frame sequencer
  // ************************************************************
  lks_state_t next_state;
  logic [2:0] next_slot;
  logic [3:0] next_ksCnt;
  logic next_commonLevel, next_scanPeriodFlag;
  logic [7:0] next_commonSelect;
  logic [23:0] next_segmentOutput;

  // last slot index per multiplex mode
  always_comb begin
    modeStatic = 1'b0;
    unique case (ctrl[`LKS_CTRL_MODE_HI:`LKS_CTRL_MODE_LO])
      `LKS_MODE_2: slotLast = 3'h1;
      `LKS_MODE_3: slotLast = 3'h2;
      `LKS_MODE_4: slotLast = 3'h3;
      `LKS_MODE_8: slotLast = 3'h7; // [R02]
      default: begin
        slotLast = 3'h0;
        modeStatic = 1'b1;
      end
    endcase
  end

  // slot and scan period stepping, one slot or half per lcd clock
  always_comb begin
    next_state = state;
    next_slot = slot;
    next_ksCnt = ksCnt;
    next_commonLevel = commonLevel;
    frameEnd = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_slot = 3'h0;
        if (ctrl[`LKS_CTRL_DISP_ON] && lcdTick) begin
          next_state = ST_DISP;
        end
      end
      ST_DISP: begin
        if (!ctrl[`LKS_CTRL_DISP_ON]) begin
          next_state = ST_IDLE;
        end else if (lcdTick) begin
          if (slot >= slotLast) begin
            frameEnd = 1'b1;
            next_slot = 3'h0;
            next_commonLevel = ~commonLevel; // [R04]
            if (ctrl[`LKS_CTRL_KS_EN] && !modeStatic) begin // [R06] [R16]
              next_state = ST_KS_FIRST;
              next_ksCnt = 4'h0;
            end
          end else begin
            next_slot = slot + 3'h1;
          end
        end
      end
      ST_KS_FIRST: begin
        if (lcdTick) begin
          next_ksCnt = ksCnt + 4'h1;
          next_state = ST_KS_LATTER; // [R13]
        end
      end
      ST_KS_LATTER: begin
        if (lcdTick) begin
          next_ksCnt = ksCnt + 4'h1;
          next_state = ctrl[`LKS_CTRL_DISP_ON] ? ST_DISP : ST_IDLE; // [R13]
        end
      end
    endcase
  end

  // pin drive: segments opposite the common when selected, scan levels in scan periods
  always_comb begin
    next_commonSelect = 8'h00;
    next_segmentOutput = {24{next_commonLevel}};
    next_scanPeriodFlag = (next_state == ST_KS_FIRST) || (next_state == ST_KS_LATTER); // [R19]
    if (next_state == ST_DISP) begin
      next_commonSelect[next_slot] = 1'b1;
      for (int i = 0; i < 24; i++) begin
        // selected bit flips the segment against the common level
        next_segmentOutput[i] = next_commonLevel ^ dispMem[i][next_slot]; // [R01] [R03] [R04]
      end
    end else if (next_state == ST_KS_FIRST) begin
      // commons stay deselected so the panel sees no select pulse
      next_segmentOutput[19:16] = patA[3:0]; // [R05] [R11] [R12] [R14]
      next_segmentOutput[23:20] = patB[3:0]; // [R11] [R12]
    end else if (next_state == ST_KS_LATTER) begin
      next_segmentOutput[19:16] = patA[7:4]; // [R11] [R12]
      next_segmentOutput[23:20] = patB[7:4]; // [R11] [R12]
    end
  end

  // return sampling window, excluding the hold-off and the final lcd clock
  always_comb begin
    ksAccept = scanPeriodFlag && (ksCnt >= `LKS_RET_HOLDOFF) // [R07]
               && (ksCnt < `LKS_KS_LEN - 4'h1); // [R17]
    retHit = ksAccept && |(~retSync & returnMode); // [R08]
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      slot <= 3'h0;
      ksCnt <= 4'h0;
      commonLevel <= 1'b0;
      commonSelect <= 8'h00;
      segmentOutput <= 24'h000000;
      scanPeriodFlag <= 1'b0;
    end else begin
      state <= next_state;
      slot <= next_slot;
      ksCnt <= next_ksCnt;
      commonLevel <= next_commonLevel;
      commonSelect <= next_commonSelect;
      segmentOutput <= next_segmentOutput;
      scanPeriodFlag <= next_scanPeriodFlag;
    end
  end

  // ************************************************************
  // axi4-lite slave and register file
  // ************************************************************
  logic [17:0] wIdx, rIdx;
  logic wrFire, rdFire, memWe;
  logic [4:0] memAddr;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [7:0] next_ctrl, next_intStat, next_intMask, next_returnMode, next_patA, next_patB;
  logic next_irq;
  logic [7:0] wByte;

  // both write channels taken together, one transaction at a time
  always_comb begin
    wIdx = awaddr[19:2];
    rIdx = araddr[19:2];
    wByte = wdata[7:0];
    wrFire = awvalid && awready && wvalid && wready;
    rdFire = arvalid && arready;
    next_awready = awvalid && wvalid && !bvalid && !awready;
    next_wready = awvalid && wvalid && !bvalid && !awready;
    next_arready = arvalid && !rvalid && !arready;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !rready;
    next_rresp = rresp;
    next_rdata = rdata;
    next_ctrl = ctrl;
    next_intMask = intMask;
    next_returnMode = returnMode;
    next_patA = patA;
    next_patB = patB;
    next_intStat = intStat;
    memWe = 1'b0;
    memAddr = 5'(wIdx - `LKS_IDX_DMEM_FIRST);
    if (wrFire) begin
      next_bvalid = 1'b1;
      next_bresp = `LKS_RESP_OKAY;
      if (wIdx >= `LKS_IDX_DMEM_FIRST && wIdx <= `LKS_IDX_DMEM_LAST) begin
        memWe = wstrb[0];
      end else if (wIdx == `LKS_IDX_CTRL) begin
        if (wstrb[0]) next_ctrl = wByte;
      end else if (wIdx == `LKS_IDX_INT_STAT) begin
        if (wstrb[0]) next_intStat = intStat & ~wByte;
      end else if (wIdx == `LKS_IDX_INT_MASK) begin
        if (wstrb[0]) next_intMask = wByte;
      end else if (wIdx == `LKS_IDX_RET_MODE) begin
        if (wstrb[0]) next_returnMode = wByte;
      end else if (wIdx == `LKS_IDX_PAT_A) begin
        if (wstrb[0]) next_patA = wByte;
      end else if (wIdx == `LKS_IDX_PAT_B) begin
        if (wstrb[0]) next_patB = wByte;
      end else if (wIdx != `LKS_IDX_STATUS) begin
        next_bresp = `LKS_RESP_SLVERR;
      end
    end
    // hardware set wins over a clear in the same cycle
    if (retHit) next_intStat[`LKS_INT_RETURN] = 1'b1; // [R08]
    if (frameEnd) next_intStat[`LKS_INT_FRAME] = 1'b1;
    next_irq = |(next_intStat & next_intMask);
    if (rdFire) begin
      next_rvalid = 1'b1;
      next_rresp = `LKS_RESP_OKAY;
      next_rdata = 32'h0;
      if (rIdx >= `LKS_IDX_DMEM_FIRST && rIdx <= `LKS_IDX_DMEM_LAST) begin
        next_rdata[7:0] = dispMem[5'(rIdx - `LKS_IDX_DMEM_FIRST)];
      end else if (rIdx == `LKS_IDX_CTRL) begin
        next_rdata[7:0] = ctrl;
      end else if (rIdx == `LKS_IDX_STATUS) begin
        // polled by software before key identification
        next_rdata[7:0] = {3'h0, slot, commonLevel, scanPeriodFlag}; // [R09] [R19]
      end else if (rIdx == `LKS_IDX_INT_STAT) begin
        next_rdata[7:0] = intStat;
      end else if (rIdx == `LKS_IDX_INT_MASK) begin
        next_rdata[7:0] = intMask;
      end else if (rIdx == `LKS_IDX_RET_MODE) begin
        next_rdata[7:0] = returnMode;
      end else if (rIdx == `LKS_IDX_PAT_A) begin
        next_rdata[7:0] = patA;
      end else if (rIdx == `LKS_IDX_PAT_B) begin
        next_rdata[7:0] = patB;
      end else begin
        next_rresp = `LKS_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `LKS_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= `LKS_RESP_OKAY;
      rdata <= 32'h0;
      ctrl <= `LKS_CTRL_RST;
      intStat <= `LKS_BYTE_RST;
      intMask <= `LKS_BYTE_RST;
      returnMode <= `LKS_BYTE_RST;
      patA <= `LKS_BYTE_RST;
      patB <= `LKS_BYTE_RST;
      irq <= 1'b0;
    end else begin
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      ctrl <= next_ctrl;
      intStat <= next_intStat;
      intMask <= next_intMask;
      returnMode <= next_returnMode;
      patA <= next_patA;
      patB <= next_patB;
      irq <= next_irq;
    end
  end

  // display memory has no reset; software fills it before display on
  always_ff @(posedge sys_clk) begin
    if (memWe) begin
      dispMem[memAddr] <= wByte;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_com_quiet;
    scanPeriodFlag |-> commonSelect == 8'h00;
  endproperty
  a_com_quiet: assert property (p_com_quiet) else $error("common selected in scan period"); // [R14]

  property p_flag_state;
    scanPeriodFlag == ((state == ST_KS_FIRST) || (state == ST_KS_LATTER));
  endproperty
  a_flag_state: assert property (p_flag_state) else $error("scan flag disagrees with state"); // [R19]

  property p_ks_allowed;
    $rose(scanPeriodFlag) |-> $past(ctrl[`LKS_CTRL_KS_EN]) && !$past(modeStatic);
  endproperty
  a_ks_allowed: assert property (p_ks_allowed) else $error("scan period not allowed"); // [R16]

  property p_holdoff;
    $rose(intStat[`LKS_INT_RETURN]) |-> $past(scanPeriodFlag) && $past(ksCnt) >= 4'h2;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("return flag set too early"); // [R07]

  property p_last_clock;
    $rose(intStat[`LKS_INT_RETURN]) |-> $past(ksCnt) != 4'h1;
  endproperty
  a_last_clock: assert property (p_last_clock) else $error("return taken in last clock"); // [R17]

  property p_ret_cause;
    $rose(intStat[`LKS_INT_RETURN]) |-> $past(|(~retSync & returnMode));
  endproperty
  a_ret_cause: assert property (p_ret_cause) else $error("return flag without pressed key"); // [R08]

  property p_first_half;
    state == ST_KS_FIRST |-> segmentOutput[19:16] == $past(patA[3:0])
      && segmentOutput[23:20] == $past(patB[3:0]);
  endproperty
  a_first_half: assert property (p_first_half) else $error("first half pins wrong"); // [R11]

  property p_latter_half;
    state == ST_KS_LATTER |-> segmentOutput[19:16] == $past(patA[7:4])
      && segmentOutput[23:20] == $past(patB[7:4]);
  endproperty
  a_latter_half: assert property (p_latter_half) else $error("latter half pins wrong"); // [R12]

  property p_half_len;
    $fell(state == ST_KS_FIRST) |-> $past(lcdTick) && state == ST_KS_LATTER;
  endproperty
  a_half_len: assert property (p_half_len) else $error("first half not one lcd clock"); // [R13]

  property p_segment_output_0;
    state == ST_DISP && $past(state) == ST_DISP
      |-> segmentOutput[0] == (commonLevel ^ $past(dispMem[0][next_slot]));
  endproperty
  a_segment_output_0: assert property (p_segment_output_0) else $error("segment 0 pattern wrong"); // [R01]

  property p_polarity;
    $rose(scanPeriodFlag) |-> commonLevel != $past(commonLevel);
  endproperty
  a_polarity: assert property (p_polarity) else $error("frame polarity not flipped"); // [R04]
endmodule
`default_nettype wire

// *** rtl/lks_consts.svh ***
// offsets, field positions, reset values and timing counts of the lcd key scan block
`ifndef LKS_CONSTS_SVH
`define LKS_CONSTS_SVH
// register indices, byte address is four times the index
`define LKS_IDX_DMEM_FIRST 18'h0FA40
`define LKS_IDX_DMEM_LAST 18'h0FA57
`define LKS_IDX_CTRL 18'h0FA60
`define LKS_IDX_STATUS 18'h0FA61
`define LKS_IDX_INT_STAT 18'h0FA62
`define LKS_IDX_INT_MASK 18'h0FA63
`define LKS_IDX_RET_MODE 18'h0FA64
`define LKS_IDX_PAT_A 18'h0FA65
`define LKS_IDX_PAT_B 18'h0FA66
// control fields
`define LKS_CTRL_DISP_ON 0
`define LKS_CTRL_KS_EN 1
`define LKS_CTRL_MODE_LO 4
`define LKS_CTRL_MODE_HI 6
`define LKS_MODE_STATIC 3'h0
`define LKS_MODE_2 3'h1
`define LKS_MODE_3 3'h2
`define LKS_MODE_4 3'h3
`define LKS_MODE_8 3'h4
// interrupt status bits
`define LKS_INT_RETURN 0
`define LKS_INT_FRAME 1
// reset values
`define LKS_CTRL_RST 8'h00
`define LKS_BYTE_RST 8'h00
// timing: sys clock 4 ns, lcd clock period as printed in ns
`define LKS_SYS_PERIOD_NS 4
`define LKS_LCD_PERIOD_NS 244140
`define LKS_LCD_DIV (`LKS_LCD_PERIOD_NS / `LKS_SYS_PERIOD_NS)
// key return gating in lcd clocks
`define LKS_RET_HOLDOFF 4'h2
`define LKS_KS_LEN 4'h2
`define LKS_RESP_OKAY 2'h0
`define LKS_RESP_SLVERR 2'h2
`endif

// *** rtl/lks_pkg.sv ***
// types of the lcd key scan block
package lks_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DISP,
    ST_KS_FIRST,
    ST_KS_LATTER
  } lks_state_t;
endpackage

// *** rtl/lks_sync.sv ***
// two-flop synchroniser for the key return pins
`timescale 1ns/1ns
`default_nettype none
module lks_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // pins and synchronised levels
  input wire logic [7:0] pinIn,
  output logic [7:0] pinSync
);
  logic [7:0] stage1;
  logic [7:0] next_stage1;
  logic [7:0] next_pinSync;

  // stage one feeds only stage two
  always_comb begin
    next_stage1 = pinIn;
    next_pinSync = stage1;
  end

  // idle level of a return line is high
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= 8'hFF;
      pinSync <= 8'hFF;
    end else begin
      stage1 <= next_stage1;
      pinSync <= next_pinSync;
    end
  end
endmodule
`default_nettype wire

// *** rtl/lks_top_unused_placeholder.sv ***
// intentionally empty design unit file holding no logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// *** dv/lks_key_matrix.sv ***
// diode key matrix hanging on the shared scan pins and the return lines
`timescale 1ns/1ns
`default_nettype none
module lks_key_matrix (
  // shared scan pins as driven by the device
  input wire logic [7:0] scanPins,
  // keys held down, bit 8*r+k joins return r to scan pin k
  input wire logic [63:0] keyDown,
  // return lines, each with a pull-up
  output logic [7:0] returnLines
);
  // ****************************************
  // diode path from return line to scan pin
  // ****************************************
  // a low pin pulls every pressed return low, also in display periods
  always_comb begin
    for (int r = 0; r < 8; r++) begin
      returnLines[r] = 1'b1;
      for (int k = 0; k < 8; k++) begin
        if (keyDown[8*r+k] && scanPins[k] == 1'b0) begin
          returnLines[r] = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the lcd key scan block
`timescale 1ns/1ns
`default_nettype none
`include "lks_consts.svh"
module tb_top;
  localparam int LCD_DIV = 8;
  localparam logic [17:0] REG_IDX [6] = '{`LKS_IDX_CTRL, `LKS_IDX_INT_STAT,
    `LKS_IDX_INT_MASK, `LKS_IDX_RET_MODE, `LKS_IDX_PAT_A, `LKS_IDX_PAT_B};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [19:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, commonLevel, scanPeriodFlag, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] segmentOutput, expSeg;
  logic [7:0] commonSelect, returnInput, patA, patB;
  logic [7:0] memCopy [24];
  logic [63:0] keyDown = '0;
  logic watchOn = 1'b0, synced = 1'b0, prevFlag = 1'b0, lastLevel = 1'b0, levelKnown = 1'b0;
  int ksCnt = 0, flagRises = 0, errors = 0, samplesChecked = 0;

  always #2 sys_clk = ~sys_clk;

  lks_top #(.LCD_DIV(LCD_DIV)) u_lks_top (.sys_clk(sys_clk), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .segmentOutput(segmentOutput),
    .commonSelect(commonSelect), .commonLevel(commonLevel), .returnInput(returnInput),
    .scanPeriodFlag(scanPeriodFlag), .irq(irq));

  lks_key_matrix u_lks_key_matrix (.scanPins(segmentOutput[23:16]), .keyDown(keyDown),
    .returnLines(returnInput));

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // starts one edge late so no strobe is assigned twice in a time step
  task automatic axi_wr(input logic [17:0] idx, input logic [7:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    rs = bresp;
    bready <= 1'b0;
    if (n >= 100) check(32'h0, 32'h1);
  endtask

  task automatic axi_rd(input logic [17:0] idx, output logic [7:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata[7:0];
    rs = rresp;
    rready <= 1'b0;
    if (n >= 100) check(32'h0, 32'h1);
  endtask

  task automatic wr_chk(input logic [17:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] rs;
    axi_wr(idx, d, rs);
    check({30'h0, rs}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [17:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic [7:0] d;
    logic [1:0] rs;
    axi_rd(idx, d, rs);
    check({22'h0, rs, d}, {22'h0, er, ed});
  endtask

  // watch is paused around control writes, a cut scan period is not judged
  task automatic set_ctrl(input logic [7:0] v);
    watchOn = 1'b0;
    wr_chk(`LKS_IDX_CTRL, v, `LKS_RESP_OKAY);
    watchOn = 1'b1;
  endtask

  task automatic wait_lcd(input int n);
    repeat (n * LCD_DIV) @(posedge sys_clk);
  endtask

  // ****************************************
  // pin watch against mirrored memory and patterns
  // ****************************************
  always @(negedge sys_clk) begin
    if (scanPeriodFlag === 1'b1 && prevFlag === 1'b0) flagRises++;
    prevFlag = scanPeriodFlag;
    if (!watchOn) begin
      synced = 1'b0;
      levelKnown = 1'b0;
      ksCnt = 0;
    end else if (scanPeriodFlag === 1'b1 && synced) begin
      // one frame end lies between two scan periods, so the level must have flipped
      if (ksCnt == 0 && levelKnown) check({31'h0, commonLevel}, {31'h0, ~lastLevel});
      if (ksCnt == 0) lastLevel = commonLevel;
      if (ksCnt == 0) levelKnown = 1'b1;
      check({24'h0, commonSelect}, 32'h0);
      if (ksCnt < LCD_DIV) begin
        check({24'h0, segmentOutput[23:16]}, {24'h0, patB[3:0], patA[3:0]});
      end else begin
        check({24'h0, segmentOutput[23:16]}, {24'h0, patB[7:4], patA[7:4]});
      end
      ksCnt++;
    end else if (scanPeriodFlag !== 1'b1) begin
      if (synced && ksCnt != 0) check(ksCnt, 2 * LCD_DIV);
      synced = 1'b1;
      ksCnt = 0;
      if (commonSelect !== 8'h00) begin
        for (int s = 0; s < 24; s++) begin
          expSeg[s] = commonLevel ^ (|(memCopy[s] & commonSelect));
        end
        check({8'h0, segmentOutput}, {8'h0, expSeg});
      end
    end
  end

  // ****************************************
  // test sequence and watchdog
  // ****************************************
  initial begin
    logic [7:0] d;
    logic [1:0] rs;
    int n;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (REG_IDX[i]) rd_chk(REG_IDX[i], `LKS_BYTE_RST, `LKS_RESP_OKAY);
    wr_chk(`LKS_IDX_STATUS, 8'hFF, `LKS_RESP_OKAY);
    rd_chk(`LKS_IDX_STATUS, 8'h00, `LKS_RESP_OKAY);
    wr_chk(18'h0FA58, 8'h55, `LKS_RESP_SLVERR);
    rd_chk(18'h0FA58, 8'h00, `LKS_RESP_SLVERR);
    rd_chk(18'h0FA3F, 8'h00, `LKS_RESP_SLVERR);
    $display("test registers done");
    for (int s = 0; s < 24; s++) begin
      memCopy[s] = (s == 12) ? 8'h0D : (s == 4) ? 8'h31 : 8'(s * 8'h35 + 8'h5A);
      wr_chk(`LKS_IDX_DMEM_FIRST + 18'(s), memCopy[s], `LKS_RESP_OKAY);
    end
    for (int s = 0; s < 24; s++) begin
      rd_chk(`LKS_IDX_DMEM_FIRST + 18'(s), memCopy[s], `LKS_RESP_OKAY);
    end
    patA = 8'hE1; // halves inverted to drain panel charge
    patB = 8'h87;
    wr_chk(`LKS_IDX_PAT_A, patA, `LKS_RESP_OKAY);
    wr_chk(`LKS_IDX_PAT_B, patB, `LKS_RESP_OKAY);
    rd_chk(`LKS_IDX_PAT_A, patA, `LKS_RESP_OKAY);
    rd_chk(`LKS_IDX_PAT_B, patB, `LKS_RESP_OKAY);
    wr_chk(`LKS_IDX_RET_MODE, 8'hFF, `LKS_RESP_OKAY);
    $display("test memory done");
    for (int m = 0; m < 5; m++) begin
      for (int k = 0; k < 2; k++) begin
        set_ctrl({1'b0, 3'(m), 2'b00, 1'(k), 1'b1});
        flagRises = 0;
        wait_lcd(24);
        check({31'h0, flagRises != 0}, {31'h0, k == 1 && m != 0});
      end
    end
    $display("test modes done");
    keyDown <= 64'h1;
    n = 0;
    d = 8'h00;
    while (d[0] !== 1'b1 && n < 60) begin
      axi_rd(`LKS_IDX_STATUS, d, rs);
      n++;
    end
    check({31'h0, d[0]}, 32'h1);
    wait_lcd(30);
    axi_rd(`LKS_IDX_INT_STAT, d, rs);
    check({31'h0, d[0]}, 32'h0);
    $display("test key scan done");
    set_ctrl(8'h11);
    wait_lcd(8);
    rd_chk(`LKS_IDX_INT_STAT, 8'h02, `LKS_RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    wr_chk(`LKS_IDX_INT_MASK, 8'h02, `LKS_RESP_OKAY);
    repeat (4) @(posedge sys_clk);
    check({31'h0, irq}, 32'h1);
    set_ctrl(8'h00);
    wr_chk(`LKS_IDX_INT_STAT, 8'h02, `LKS_RESP_OKAY);
    rd_chk(`LKS_IDX_INT_STAT, 8'h00, `LKS_RESP_OKAY);
    repeat (4) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    report_and_stop();
  end

  // whole sequence needs under 5000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
